// file: rtl/nvm_program_ctrl.sv
// Top of the EEPROM program/erase control: Avalon-MM register slave,
// control interlocks, programming latches and array strobes.
// Assumes the CPU array port gives one-cycle write strobes with a 10-bit
// byte offset, and that the array macro obeys the registered outputs.
`timescale 1ns/1ps
`default_nettype none

module nvm_program_ctrl
    import nvm_prog_pkg::*;
(
    input wire logic MCLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic [ADDR_W-1:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    input wire logic [3:0] AVS_BYTEENABLE_IN,
    output logic [31:0] AVS_READDATA_OUT,
    output logic AVS_WAITREQUEST_OUT,
    input wire logic ARR_WR_IN,
    input wire logic [ARR_AW-1:0] ARR_ADDR_IN,
    input wire logic [15:0] ARR_WDATA_IN,
    input wire logic ARR_WORD_IN,
    output logic ARR_READ_ENABLE_OUT,
    output logic ARR_ERASE_MODE_OUT,
    output logic [1:0] ARR_OP_OUT,
    output logic [ARR_AW-1:0] ARR_LATCH_ADDR_OUT,
    output logic [15:0] ARR_PGM_DATA_OUT,
    output logic ARR_LATCH_WORD_OUT,
    output logic ARR_HV_OUT,
    output logic ARR_REFUSED_OUT
);

    // ****************************************
    // State
    // ****************************************
    logic [7:0] control_reg;
    logic [7:0] control_next;
    logic [GUARD_N-1:0] guard_reg;
    logic prot_lock_reg;
    logic latch_valid_reg;
    logic [ARR_AW-1:0] latch_addr_reg;
    logic [15:0] latch_data_reg;
    logic latch_word_reg;
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic read_en_reg;
    logic erase_mode_reg;
    logic [1:0] op_reg;
    logic hv_out_reg;
    logic refused_reg;
    logic [15:0] pgm_data_reg;

    logic bus_req;
    logic wr_take;
    logic [7:0] wr_index;
    logic wr_hit_ctrl;
    logic wr_hit_guard;
    logic wr_hit_cfg;
    logic [7:0] wdata8;
    logic hv;
    nvm_op_e dec_op;
    logic dec_refused;
    logic arr_take;

    // ****************************************
    // Avalon-MM slave: one wait state on every access
    // ****************************************
    function automatic logic [7:0] index_of(input logic [ADDR_W-1:0] a);
        index_of = a[9:2];
    endfunction : index_of

    assign bus_req = AVS_READ_IN || AVS_WRITE_IN;
    assign wr_take = AVS_WRITE_IN && !wait_reg && AVS_BYTEENABLE_IN[0];
    assign wr_index = index_of(AVS_ADDRESS_IN);
    assign wr_hit_ctrl = wr_take && (wr_index == IDX_CONTROL)
        && (AVS_ADDRESS_IN[1:0] == BYTE_SEL_BITS);
    assign wr_hit_guard = wr_take && (wr_index == IDX_GUARD)
        && (AVS_ADDRESS_IN[1:0] == BYTE_SEL_BITS);
    assign wr_hit_cfg = wr_take && (wr_index == IDX_CONFIG)
        && (AVS_ADDRESS_IN[1:0] == BYTE_SEL_BITS);
    assign wdata8 = AVS_WRITEDATA_IN[7:0];
    assign hv = control_reg[BIT_HV];

    // Wait is released for exactly one cycle, in which the master samples it
    always_ff @(posedge MCLK_IN)
    begin
        if (SYS_RST_IN)
            wait_reg <= 1'b1;
        else if (wait_reg && bus_req)
            wait_reg <= 1'b0;
        else
            wait_reg <= 1'b1;
    end

    // Unmapped indices read zero and swallow writes
    always_ff @(posedge MCLK_IN)
    begin
        if (SYS_RST_IN)
            rdata_reg <= 32'h0000_0000;
        else if (AVS_READ_IN && wait_reg)
        begin
            rdata_reg <= 32'h0000_0000;
            unique case (index_of(AVS_ADDRESS_IN))
                IDX_CONTROL:
                    rdata_reg[7:0] <= control_reg;
                IDX_GUARD:
                    rdata_reg[GUARD_N-1:0] <= guard_reg;
                IDX_CONFIG:
                    rdata_reg[BIT_PROT_LOCK] <= prot_lock_reg;
                IDX_LATCH_STATUS:
                begin
                    rdata_reg[ARR_AW-1:0] <= latch_addr_reg;
                    rdata_reg[BIT_LATCH_VALID] <= latch_valid_reg;
                    rdata_reg[BIT_LATCH_WORD] <= latch_word_reg;
                    rdata_reg[BIT_HV_ACTIVE] <= hv_out_reg;
                    rdata_reg[BIT_REFUSED] <= refused_reg;
                end
                IDX_LATCH_DATA:
                    rdata_reg[15:0] <= latch_data_reg;
                default:
                    rdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // Control register interlocks
    // ****************************************
    always_comb
    begin
        control_next = control_reg;
        if (wr_hit_ctrl)
        begin
            if (hv)
            begin
                // Only the pulse can end; clearing it also applies the latch
                // bit so that the closing write of a sequence takes effect
                control_next[BIT_HV] = wdata8[BIT_HV];
                if (!wdata8[BIT_HV])
                    control_next[BIT_LATCH] = wdata8[BIT_LATCH];
            end
            else
            begin
                // Setup bits are taken on their own, bulk guard only while unlocked, so any order works
                control_next[BIT_SINGLE_ERASE] = wdata8[BIT_SINGLE_ERASE];
                control_next[BIT_LINE_ERASE] = wdata8[BIT_LINE_ERASE];
                control_next[BIT_WIPE] = wdata8[BIT_WIPE];
                control_next[BIT_LATCH] = wdata8[BIT_LATCH];
                if (!prot_lock_reg)
                    control_next[BIT_BULK_GUARD] = wdata8[BIT_BULK_GUARD];
                // Old and written latch bits must both be set; a joint set leaves hv clear
                control_next[BIT_HV] = wdata8[BIT_HV]
                    && control_reg[BIT_LATCH]
                    && wdata8[BIT_LATCH];
            end
        end
        control_next[6:5] = 2'b00;
    end

    always_ff @(posedge MCLK_IN)
    begin
        if (SYS_RST_IN)
            control_reg <= CONTROL_RESET;
        else
            control_reg <= control_next;
    end

    // ****************************************
    // Protection registers
    // ****************************************
    always_ff @(posedge MCLK_IN)
    begin
        if (SYS_RST_IN)
            prot_lock_reg <= 1'b0;
        else if (wr_hit_cfg)
            prot_lock_reg <= wdata8[BIT_PROT_LOCK];
    end

    always_ff @(posedge MCLK_IN)
    begin
        if (SYS_RST_IN)
            guard_reg <= GUARD_RESET;
        else if (wr_hit_guard && !hv && !prot_lock_reg)
            guard_reg <= wdata8[GUARD_N-1:0];
    end

    // ****************************************
    // Programming latches
    // ****************************************
    // Relatching of offsets below ARR_END is allowed whenever latch setup is on and the pulse is off,
    // which lets software step through several locations
    assign arr_take = ARR_WR_IN && control_reg[BIT_LATCH] && !hv
        && (ARR_ADDR_IN < ARR_END);

    always_ff @(posedge MCLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            latch_valid_reg <= 1'b0;
            latch_addr_reg <= '0;
            latch_data_reg <= 16'h0000;
            latch_word_reg <= 1'b0;
        end
        else if (!control_reg[BIT_LATCH])
            latch_valid_reg <= 1'b0;
        else if (arr_take)
        begin
            latch_valid_reg <= 1'b1;
            latch_addr_reg <= ARR_ADDR_IN;
            if (ARR_WORD_IN && !ARR_ADDR_IN[0])
            begin
                latch_data_reg <= ARR_WDATA_IN;
                latch_word_reg <= 1'b1;
            end
            else
            begin
                // A misaligned word keeps only its lower byte
                latch_data_reg <= {8'h00, ARR_WDATA_IN[7:0]};
                latch_word_reg <= 1'b0;
            end
        end
    end

    nvm_op_decode u_decode (
        .bulk_guard_in(control_reg[BIT_BULK_GUARD]),
        .single_erase_in(control_reg[BIT_SINGLE_ERASE]),
        .line_erase_in(control_reg[BIT_LINE_ERASE]),
        .wipe_in(control_reg[BIT_WIPE]),
        .guard_in(guard_reg),
        .addr_in(latch_addr_reg),
        .op_out(dec_op),
        .refused_out(dec_refused)
    );

    // ****************************************
    // Array strobes
    // ****************************************
    // Read gating follows the next latch value so the array is fenced off
    // from the same edge that latch setup takes effect
    always_ff @(posedge MCLK_IN)
    begin
        if (SYS_RST_IN)
            read_en_reg <= 1'b1;
        else
            read_en_reg <= !control_next[BIT_LATCH];
    end

    // No timeout: the pump follows hv_apply for as long as it is held
    always_ff @(posedge MCLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            hv_out_reg <= 1'b0;
            refused_reg <= 1'b0;
        end
        else
        begin
            hv_out_reg <= hv && latch_valid_reg && !dec_refused;
            refused_reg <= hv && dec_refused;
        end
    end

    always_ff @(posedge MCLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            erase_mode_reg <= 1'b0;
            op_reg <= OP_PROGRAM;
            pgm_data_reg <= ERASED_WORD;
        end
        else
        begin
            erase_mode_reg <= control_reg[BIT_WIPE];
            op_reg <= dec_op;
            pgm_data_reg <= control_reg[BIT_WIPE] ? ERASED_WORD
                : latch_data_reg;
        end
    end

    assign AVS_WAITREQUEST_OUT = wait_reg;
    assign AVS_READDATA_OUT = rdata_reg;
    assign ARR_READ_ENABLE_OUT = read_en_reg;
    assign ARR_ERASE_MODE_OUT = erase_mode_reg;
    assign ARR_OP_OUT = op_reg;
    assign ARR_LATCH_ADDR_OUT = latch_addr_reg;
    assign ARR_PGM_DATA_OUT = pgm_data_reg;
    assign ARR_LATCH_WORD_OUT = latch_word_reg;
    assign ARR_HV_OUT = hv_out_reg;
    assign ARR_REFUSED_OUT = refused_reg;

endmodule : nvm_program_ctrl

`default_nettype wire

// file: rtl/nvm_prog_pkg.sv
// Constants, field layouts and types for the EEPROM program/erase control.
// Assumes a 768-byte array seen as a 10-bit byte offset from its base.

package nvm_prog_pkg;

    // ****************************************
    // Register map (index, byte address = 4 * index)
    // ****************************************
    localparam int ADDR_W = 12;
    localparam logic [7:0] IDX_CONFIG = 8'hF0;
    localparam logic [7:0] IDX_GUARD = 8'hF1;
    localparam logic [7:0] IDX_CONTROL = 8'hF3;
    localparam logic [7:0] IDX_LATCH_STATUS = 8'hF8;
    localparam logic [7:0] IDX_LATCH_DATA = 8'hF9;
    localparam logic [1:0] BYTE_SEL_BITS = 2'h0;

    // ****************************************
    // Control, config and latch status register fields
    // ****************************************
    localparam int BIT_BULK_GUARD = 7;
    localparam int BIT_SINGLE_ERASE = 4;
    localparam int BIT_LINE_ERASE = 3;
    localparam int BIT_WIPE = 2;
    localparam int BIT_LATCH = 1;
    localparam int BIT_HV = 0;
    localparam int BIT_PROT_LOCK = 0;
    localparam int BIT_LATCH_VALID = 31;
    localparam int BIT_LATCH_WORD = 30;
    localparam int BIT_HV_ACTIVE = 29;
    localparam int BIT_REFUSED = 28;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [4:0] GUARD_RESET = 5'h00;

    // ****************************************
    // Array geometry and block guard ranges
    // ****************************************
    localparam int ARR_AW = 10;
    localparam int GUARD_N = 5;
    localparam logic [9:0] ARR_END = 10'h300;
    localparam logic [9:0] BLK3_BASE = 10'h100;
    localparam logic [9:0] BLK2_BASE = 10'h200;
    localparam logic [9:0] BLK1_BASE = 10'h280;
    localparam logic [9:0] BLK0_BASE = 10'h2C0;
    localparam int ROW_BYTES = 32;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;

    typedef enum logic [1:0] {
        OP_PROGRAM,
        OP_ERASE_LOC,
        OP_ERASE_ROW,
        OP_ERASE_BULK
    } nvm_op_e;

endpackage : nvm_prog_pkg

// file: rtl/nvm_op_decode.sv
// Decodes the control bits and the latched address into an operation kind
// and a refusal flag. Purely combinational; the top registers the results.
`timescale 1ns/1ps
`default_nettype none

module nvm_op_decode
    import nvm_prog_pkg::*;
(
    input wire logic bulk_guard_in,
    input wire logic single_erase_in,
    input wire logic line_erase_in,
    input wire logic wipe_in,
    input wire logic [GUARD_N-1:0] guard_in,
    input wire logic [ARR_AW-1:0] addr_in,
    output nvm_op_e op_out,
    output logic refused_out
);

    // ****************************************
    // Block lookup for an array offset
    // ****************************************
    function automatic logic [2:0] block_of(input logic [ARR_AW-1:0] a);
        if (a < BLK3_BASE)
            block_of = 3'd4;
        else if (a < BLK2_BASE)
            block_of = 3'd3;
        else if (a < BLK1_BASE)
            block_of = 3'd2;
        else if (a < BLK0_BASE)
            block_of = 3'd1;
        else
            block_of = 3'd0;
    endfunction : block_of

    logic loc_guarded;

    // Rows are 32 bytes and blocks are multiples of 64, so a row never
    // straddles two blocks and the latched address names its block
    assign loc_guarded = guard_in[block_of(addr_in)];

    always_comb
    begin
        op_out = OP_PROGRAM;
        refused_out = loc_guarded;
        if (wipe_in)
        begin
            if (single_erase_in)
                op_out = OP_ERASE_LOC;
            else if (line_erase_in)
            begin
                op_out = OP_ERASE_ROW;
                refused_out = loc_guarded || bulk_guard_in;
            end
            else
            begin
                op_out = OP_ERASE_BULK;
                refused_out = (|guard_in) || bulk_guard_in;
            end
        end
    end

endmodule : nvm_op_decode

`default_nettype wire

// file: tb/nvm_program_monitor.sv
// Checker for the program/erase control, watching top-level ports only.
// Assumes the register map and one-cycle output latencies of the package.
`timescale 1ns/1ps
`default_nettype none

module nvm_program_monitor
    import nvm_prog_pkg::*;
(
    input wire logic MCLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic [ADDR_W-1:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    input wire logic [3:0] AVS_BYTEENABLE_IN,
    input wire logic [31:0] AVS_READDATA_OUT,
    input wire logic AVS_WAITREQUEST_OUT,
    input wire logic ARR_READ_ENABLE_OUT,
    input wire logic ARR_ERASE_MODE_OUT,
    input wire logic [1:0] ARR_OP_OUT,
    input wire logic [ARR_AW-1:0] ARR_LATCH_ADDR_OUT,
    input wire logic [15:0] ARR_PGM_DATA_OUT,
    input wire logic ARR_HV_OUT,
    input wire logic ARR_REFUSED_OUT
);
    localparam logic [ADDR_W-1:0] CTL_A = {2'h0, IDX_CONTROL, BYTE_SEL_BITS};
    logic ctl_wr;
    logic ctl_rd;
    logic [7:0] wd;
    assign wd = AVS_WRITEDATA_IN[7:0];
    assign ctl_wr = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT &&
        AVS_ADDRESS_IN == CTL_A && AVS_BYTEENABLE_IN[0];
    assign ctl_rd = AVS_READ_IN && !AVS_WAITREQUEST_OUT &&
        AVS_ADDRESS_IN == CTL_A;

    default clocking mon_cb @(posedge MCLK_IN);
    endclocking
    default disable iff (SYS_RST_IN);

    // ****************
    // Interlocks
    // ****************
    latch_read_a: assert property (ctl_wr && wd[1] |->
        ##[1:2] !ARR_READ_ENABLE_OUT) else $error("array still readable");
    read_back_a: assert property (ctl_wr && wd[1:0] == 2'h0 |->
        ##[1:2] ARR_READ_ENABLE_OUT) else $error("array reads not restored");
    // Read enable high means latch_setup was clear when the write landed
    hv_joint_a: assert property (
        ctl_wr && wd[1:0] == 2'h3 && ARR_READ_ENABLE_OUT |=> !ARR_HV_OUT [*4])
        else $error("hv set together with latch");
    hv_off_a: assert property (ctl_wr && !wd[0] |-> ##2 !ARR_HV_OUT)
        else $error("high voltage not removed");
    hv_hold_a: assert property (
        ARR_HV_OUT && !ctl_wr && !$past(ctl_wr) |=> ARR_HV_OUT)
        else $error("high voltage dropped by itself");
    latch_frozen_a: assert property (ARR_HV_OUT ##1 ARR_HV_OUT |->
        $stable(ARR_LATCH_ADDR_OUT) && $stable(ARR_PGM_DATA_OUT) &&
        $stable(ARR_ERASE_MODE_OUT)) else $error("latches moved under hv");
    ctl_pad_a: assert property (ctl_rd |->
        AVS_READDATA_OUT[31:8] == 24'h00_0000 &&
        AVS_READDATA_OUT[6:5] == 2'h0) else $error("unused bits not zero");
    op_mode_a: assert property (
        ARR_ERASE_MODE_OUT == (ARR_OP_OUT != OP_PROGRAM))
        else $error("operation disagrees with erase mode");
    erase_data_a: assert property (ARR_ERASE_MODE_OUT |->
        ARR_PGM_DATA_OUT == ERASED_WORD) else $error("erase data not ones");
    refuse_hv_a: assert property (ARR_REFUSED_OUT |-> !ARR_HV_OUT)
        else $error("pump on for refused operation");

    cover property (ARR_HV_OUT && ARR_ERASE_MODE_OUT);
    cover property (ARR_REFUSED_OUT);
    cover property (ctl_wr && wd[1:0] == 2'h3);
endmodule : nvm_program_monitor

bind nvm_program_ctrl nvm_program_monitor i_mon (
    .MCLK_IN(MCLK_IN), .SYS_RST_IN(SYS_RST_IN),
    .AVS_ADDRESS_IN(AVS_ADDRESS_IN), .AVS_READ_IN(AVS_READ_IN),
    .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN),
    .AVS_BYTEENABLE_IN(AVS_BYTEENABLE_IN),
    .AVS_READDATA_OUT(AVS_READDATA_OUT),
    .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
    .ARR_READ_ENABLE_OUT(ARR_READ_ENABLE_OUT),
    .ARR_ERASE_MODE_OUT(ARR_ERASE_MODE_OUT), .ARR_OP_OUT(ARR_OP_OUT),
    .ARR_LATCH_ADDR_OUT(ARR_LATCH_ADDR_OUT),
    .ARR_PGM_DATA_OUT(ARR_PGM_DATA_OUT), .ARR_HV_OUT(ARR_HV_OUT),
    .ARR_REFUSED_OUT(ARR_REFUSED_OUT)
);
`default_nettype wire

// file: tb/nvm_cpu_model.sv
// CPU side of the array write port: one-cycle write strobes on request.
// Assumes put is called just after a rising edge of clk_in.
`timescale 1ns/1ps
`default_nettype none

module nvm_cpu_model
    import nvm_prog_pkg::*;
(
    input wire logic clk_in,
    output logic wr_out,
    output logic [ARR_AW-1:0] addr_out,
    output logic [15:0] data_out,
    output logic word_out
);
    initial
    begin
        wr_out = 1'b0;
        addr_out = '0;
        data_out = '0;
        word_out = 1'b0;
    end

    // Lines are inverted after the strobe so a stale value never passes
    task automatic put(input logic [ARR_AW-1:0] a, input logic [15:0] d,
        input logic w);
        wr_out <= 1'b1;
        addr_out <= a;
        data_out <= d;
        word_out <= w;
        @(posedge clk_in);
        wr_out <= 1'b0;
        addr_out <= ~a;
        data_out <= ~d;
        word_out <= ~w;
    endtask : put
endmodule : nvm_cpu_model
`default_nettype wire

// file: tb/eeprom_program_erase_ctrl_tb.sv
// Self-checking bench for the program/erase control.
// Assumes the design package map and the CPU array model beside it.
`timescale 1ns/1ps
`default_nettype none

module eeprom_program_erase_ctrl_tb
    import nvm_prog_pkg::*;
;
    localparam logic [11:0] A_CFG = {2'h0, IDX_CONFIG, BYTE_SEL_BITS};
    localparam logic [11:0] A_GRD = {2'h0, IDX_GUARD, BYTE_SEL_BITS};
    localparam logic [11:0] A_CTL = {2'h0, IDX_CONTROL, BYTE_SEL_BITS};
    localparam logic [11:0] A_BAD = 12'h03D0;
    localparam logic [7:0] T_CTL [9] = '{8'h06, 8'h0E, 8'h16, 8'h1E, 8'h12,
        8'h86, 8'h8E, 8'h96, 8'h02};
    localparam logic [1:0] T_OP [9] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h0,
        2'h3, 2'h2, 2'h1, 2'h0};
    localparam logic [8:0] T_REF = 9'h160;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [11:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, arr_wr, arr_word, read_en, erase_mode;
    logic latch_word, hv, refused;
    logic [9:0] arr_addr, latch_addr;
    logic [15:0] arr_wdata, pgm_data, d;
    logic [1:0] op;
    logic [31:0] exp_q [$];
    int failures = 0;
    int n_tests = 0;

    always #2.5 mclk = ~mclk;

    nvm_program_ctrl i_dut (
        .MCLK_IN(mclk), .SYS_RST_IN(sys_rst), .AVS_ADDRESS_IN(avs_address),
        .AVS_READ_IN(avs_read), .AVS_WRITE_IN(avs_write),
        .AVS_WRITEDATA_IN(avs_writedata), .AVS_BYTEENABLE_IN(avs_byteenable),
        .AVS_READDATA_OUT(avs_readdata), .AVS_WAITREQUEST_OUT(avs_waitrequest),
        .ARR_WR_IN(arr_wr), .ARR_ADDR_IN(arr_addr), .ARR_WDATA_IN(arr_wdata),
        .ARR_WORD_IN(arr_word), .ARR_READ_ENABLE_OUT(read_en),
        .ARR_ERASE_MODE_OUT(erase_mode), .ARR_OP_OUT(op),
        .ARR_LATCH_ADDR_OUT(latch_addr), .ARR_PGM_DATA_OUT(pgm_data),
        .ARR_LATCH_WORD_OUT(latch_word), .ARR_HV_OUT(hv),
        .ARR_REFUSED_OUT(refused)
    );

    nvm_cpu_model i_cpu (.clk_in(mclk), .wr_out(arr_wr), .addr_out(arr_addr),
        .data_out(arr_wdata), .word_out(arr_word));

    // ****************
    // Checking and bus access
    // ****************
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask : chk

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim

    task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] v);
        avs_address <= a;
        avs_writedata <= {24'($urandom), v};
        avs_byteenable <= {3'($urandom), 1'b1};
        avs_write <= w;
        avs_read <= !w;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0)
            @(posedge mclk);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge mclk);
    endtask : bus

    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        bus(1'b1, a, v);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 8'h00);
    endtask : rd

    task automatic settle();
        repeat (3) @(posedge mclk);
    endtask : settle

    always @(posedge mclk)
        if (avs_read && avs_waitrequest === 1'b0)
            chk("read data", exp_q.pop_front(), avs_readdata);

    initial
    begin
        repeat (20000) @(posedge mclk);
        failures++;
        end_sim();
    end

    // ****************
    // Scenarios
    // ****************
    initial
    begin
        void'($urandom(32'h0f21_15ca));
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        rd(A_CTL, 32'h0000_0000);
        rd(A_GRD, 32'h0000_0000);
        rd(A_BAD, 32'h0000_0000);
        chk("read enable", 1, read_en);
        wr(A_CTL, 8'hFF);
        rd(A_CTL, 32'h0000_009E);
        chk("read enable", 0, read_en);
        wr(A_CTL, 8'h00);
        wr(A_CFG, 8'h01);
        wr(A_CTL, 8'h80);
        wr(A_GRD, 8'h1F);
        rd(A_CTL, 32'h0000_0000);
        rd(A_GRD, 32'h0000_0000);
        rd(A_CFG, 32'h0000_0001);
        wr(A_CFG, 8'h00);
        wr(A_CTL, 8'h02);
        i_cpu.put(10'h010, 16'hA55A, 1'b1);
        settle();
        chk("latched address", 10'h010, latch_addr);
        chk("program data", 16'hA55A, pgm_data);
        wr(A_CTL, 8'h03);
        repeat (200) @(posedge mclk);
        chk("high voltage", 1, hv);
        wr(A_CTL, 8'h1F);
        rd(A_CTL, 32'h0000_0003);
        i_cpu.put(10'h020, 16'h1234, 1'b1);
        settle();
        chk("latched address", 10'h010, latch_addr);
        chk("program data", 16'hA55A, pgm_data);
        wr(A_CTL, 8'h02);
        settle();
        chk("high voltage", 0, hv);
        i_cpu.put(10'h031, 16'hBEEF, 1'b1);
        settle();
        chk("latched word", 0, latch_word);
        wr(A_CTL, 8'h00);
        settle();
        chk("read enable", 1, read_en);
        for (int i = 0; i < 9; i++)
        begin
            d = 16'($urandom);
            wr(A_GRD, (i == 8) ? 8'h10 : 8'h00);
            wr(A_CTL, T_CTL[i]);
            i_cpu.put(10'h010, d, 1'b1);
            wr(A_CTL, T_CTL[i] | 8'h01);
            settle();
            chk("operation", T_OP[i], op);
            chk("refused", T_REF[i], refused);
            chk("high voltage", !T_REF[i], hv);
            chk("program data", T_CTL[i][2] ? 16'hFFFF : d, pgm_data);
            wr(A_CTL, 8'h00);
        end
        end_sim();
    end
endmodule : eeprom_program_erase_ctrl_tb
`default_nettype wire
